// *** design/ddt_pkg.sv ***
package ddt_pkg;

	// data path geometry
	localparam int NBYTES = 8;
	localparam int DW     = 64;

	// register byte addresses on the apb bus
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TRIG = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_INV  = 8'h0C;
	localparam logic [7:0] A_PIPE = 8'h10;

	// control register fields
	localparam int C_RFSH = 0;
	localparam int C_LPE  = 1;
	localparam int C_ICE  = 2;
	localparam int C_DEQ  = 3;
	localparam int C_FRST = 4;
	localparam int C_RDM  = 5;
	localparam int C_DEVW = 8;
	localparam logic [31:0] CTRL_MASK = 32'h0000_037F;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0110;

	// inversion control fields
	localparam int I_RD  = 0;
	localparam int I_WR  = 1;
	localparam int I_DM  = 2;
	localparam int I_PHY = 3;

	// pipe status fields
	localparam int P_WIDLE = 0;
	localparam int P_RIDLE = 1;
	localparam int P_MVIOL = 2;
	localparam int P_CONF  = 3;

	// training trigger words and status words
	localparam logic [31:0] TRIG_PH1  = 32'h0000_0E01;
	localparam logic [31:0] TRIG_PH2  = 32'h0001_F001;
	localparam int          TRIG_GO   = 0;
	localparam logic [31:0] STAT_PH1  = 32'h0000_000E;
	localparam logic [31:0] STAT_PH2  = 32'h8000_2FF0;
	localparam logic [31:0] STAT_DONE = 32'h0000_0001;
	localparam logic [31:0] STAT_ERR  = 32'h0010_0000;
	localparam logic [31:0] STAT_PASS = 32'h8000_2FFF;

	localparam logic [1:0] RDM_STATIC = 2'h1;
	localparam logic [1:0] DEVW_X4    = 2'h0;

	// cycles one training phase occupies
	localparam int TRAIN_CYCLES = 16;
	// a byte with more zeros than this is inverted
	localparam int ZERO_LIMIT   = 4;

	typedef enum logic {TR_IDLE, TR_RUN} ddt_train_e;

	typedef struct packed {
		logic [63:0] data;
		logic [7:0]  mask;
	} ddt_wr_s;

	typedef struct packed {
		logic        wrdata_en;
		logic [63:0] wrdata;
		logic [7:0]  wrdata_mask;
	} ddt_dfi_wr_s;

	typedef struct packed {
		logic        valid;
		logic [63:0] data;
	} ddt_rd_s;

	typedef struct packed {
		logic rd_dbi;
		logic wr_dbi;
		logic dm;
		logic phy_mode;
	} ddt_inv_s;

	function automatic logic [3:0] zeros(input logic [7:0] b);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~b[i]};
		end
		return n;
	endfunction

	function automatic logic [63:0] spread(input logic [7:0] f);
		logic [63:0] m;
		m = 64'h0;
		for (int i = 0; i < 8; i++) begin
			m[8*i +: 8] = {8{f[i]}};
		end
		return m;
	endfunction

endpackage

// *** design/ddt_dbi_enc.sv ***
`timescale 1ns/1ns
module ddt_dbi_enc (
	input  wire logic [63:0] data_i,
	input  wire logic        en,
	output logic      [63:0] data_o,
	output logic      [7:0]  flag_o
);

	always_comb begin
		for (int i = 0; i < ddt_pkg::NBYTES; i++) begin
			flag_o[i] = en && (ddt_pkg::zeros(data_i[8*i +: 8]) > 4'(ddt_pkg::ZERO_LIMIT)); // [R09]
		end
		data_o = data_i ^ ddt_pkg::spread(flag_o); // [R09]
	end

endmodule // ddt_dbi_enc

// *** design/ddt_ctrl.sv ***
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// R01 - before training software sets refresh inhibit, clears low power and init-complete enable
// R02 - fifo reset bit pulsed 0 then 1 around training; fifo held while 0
// R03 - trigger word 0x00000E01 launches leveling, gate and write latency training
// R04 - done flag set when a phase ends; next phase only after success
// R05 - read mode field 0x1 selects static read mode before remaining phases
// R06 - trigger word 0x0001F001 runs static read, deskew and eye centering
// R07 - status word reports every step; 0x80002FFF means training passed
// R08 - after training software clears refresh inhibit, sets init-complete enable
// R09 - byte with more than 4 zeros is inverted, one flag per byte
// R10 - write flags ride the mask lanes, read flags come on dfi_rddata_dbi
// R11 - inversion only for x8 and x16 devices, never x4
// R12 - write inversion and data mask never together; no masked writes then
// R13 - phy-side mode: dfi data stays plain and read flags are ignored
// R14 - controller mode: flags on mask lanes, read bytes flipped per flag
// R15 - software keeps inversion enables equal to sdram mode register
// R16 - read inversion raises cas latency; software retunes dependent timings
// R17 - change inversion only with dequeue inhibited and both pipes idle; code also applies the shadow whenever training runs, with no idle check
// R18 - dequeue inhibit stops new commands; idle flags once pipes drain
// R19 - control bits static; new enables applied only while traffic held
module ddt_ctrl (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	output logic                          refresh_inhibit,
	output logic                          low_power_entry_enable,
	output logic                          init_complete_enable,
	input  wire logic                     phy_init_complete,
	output logic                          init_complete,
	output logic                          phy_fifo_reset_n,
	output logic      [1:0]               phy_read_mode_sel,
	output logic                          training_busy,
	output ddt_pkg::ddt_inv_s             inv_cfg,
	input  wire logic                     cmd_valid,
	input  wire logic                     cmd_write,
	input  wire ddt_pkg::ddt_wr_s         cmd_wr,
	output logic                          cmd_ready,
	output ddt_pkg::ddt_dfi_wr_s          dfi_wr,
	output logic                          dfi_rddata_en,
	input  wire logic                     dfi_rddata_valid,
	input  wire logic [63:0]              dfi_rddata,
	input  wire logic [7:0]               dfi_rddata_dbi,
	output ddt_pkg::ddt_rd_s              rd_ret
);

	localparam int T_RUN = ddt_pkg::TRAIN_CYCLES;

	logic [31:0]          ctrl_ff;
	logic [31:0]          trig_ff;
	logic [31:0]          stat_ff;
	logic [31:0]          prdata_ff;
	logic [7:0]           tcnt_ff;
	logic [3:0]           rpend_ff;
	logic                 mviol_ff;
	logic                 conf_ff;
	logic                 rden_ff;
	ddt_pkg::ddt_train_e  tr_ff;
	ddt_pkg::ddt_inv_s    inv_sh_ff;
	ddt_pkg::ddt_inv_s    inv_ff;
	ddt_pkg::ddt_dfi_wr_s dfi_wr_ff;
	ddt_pkg::ddt_rd_s     rd_ff;

	logic        mapped;
	logic        wr_acc;
	logic        launch;
	logic        finish;
	logic        ph1_ok;
	logic        dbi_ok;
	logic        wdbi;
	logic        wenc;
	logic        rdec;
	logic        widle;
	logic        ridle;
	logic        apply;
	logic        acc_wr;
	logic        acc_rd;
	logic        bad_wr;
	logic        mviol_clr;
	logic        conf_clr;
	logic [31:0] nxt_stat;
	logic [31:0] result;
	logic [63:0] enc_data;
	logic [7:0]  enc_flag;
	logic        wr_zero_ok;

	// apb decode: zero wait states, read data captured in the setup cycle
	always_comb begin
		case (paddr)
			ddt_pkg::A_CTRL,
			ddt_pkg::A_TRIG,
			ddt_pkg::A_STAT,
			ddt_pkg::A_INV,
			ddt_pkg::A_PIPE: mapped = 1'b1;
			default:         mapped = 1'b0;
		endcase
	end

	assign wr_acc  = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = prdata_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ddt_pkg::A_CTRL: prdata_ff <= ctrl_ff;
				ddt_pkg::A_TRIG: prdata_ff <= trig_ff;
				ddt_pkg::A_STAT: prdata_ff <= stat_ff; // [R07]
				ddt_pkg::A_INV:  prdata_ff <= {28'h0, inv_sh_ff.phy_mode, inv_sh_ff.dm,
					inv_sh_ff.wr_dbi, inv_sh_ff.rd_dbi};
				ddt_pkg::A_PIPE: prdata_ff <= {28'h0, conf_ff, mviol_ff, ridle, widle}; // [R18]
				default:         prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// control bits only move on a software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= ddt_pkg::CTRL_RST;
		end else if (wr_acc && paddr == ddt_pkg::A_CTRL) begin
			ctrl_ff <= pwdata & ddt_pkg::CTRL_MASK; // [R19]
		end
	end

	assign refresh_inhibit        = ctrl_ff[ddt_pkg::C_RFSH];
	assign low_power_entry_enable = ctrl_ff[ddt_pkg::C_LPE];
	assign init_complete_enable   = ctrl_ff[ddt_pkg::C_ICE];
	// phy init-complete toggles during training stay hidden until re-enabled
	assign init_complete          = ctrl_ff[ddt_pkg::C_ICE] && phy_init_complete; // [R01] [R08]
	assign phy_fifo_reset_n       = ctrl_ff[ddt_pkg::C_FRST]; // [R02]
	assign phy_read_mode_sel      = ctrl_ff[ddt_pkg::C_RDM +: 2]; // [R05]
	assign dbi_ok                 = ctrl_ff[ddt_pkg::C_DEVW +: 2] != ddt_pkg::DEVW_X4; // [R11]

	// training sequencer
	assign launch = wr_acc && paddr == ddt_pkg::A_TRIG && pwdata[ddt_pkg::TRIG_GO]
		&& tr_ff == ddt_pkg::TR_IDLE; // [R03]
	assign finish = tr_ff == ddt_pkg::TR_RUN && tcnt_ff == 8'(ddt_pkg::TRAIN_CYCLES - 1);
	assign ph1_ok = (stat_ff & ddt_pkg::STAT_PH1) == ddt_pkg::STAT_PH1;
	assign training_busy = tr_ff == ddt_pkg::TR_RUN;

	// the second phase only counts when the first passed and reads are static
	always_comb begin
		if (trig_ff == ddt_pkg::TRIG_PH1) begin
			result = ddt_pkg::STAT_PH1; // [R03]
		end else if (trig_ff == ddt_pkg::TRIG_PH2 && ph1_ok
			&& ctrl_ff[ddt_pkg::C_RDM +: 2] == ddt_pkg::RDM_STATIC) begin
			result = ddt_pkg::STAT_PH2; // [R05] [R06]
		end else begin
			result = ddt_pkg::STAT_ERR; // [R04]
		end
	end

	always_comb begin
		nxt_stat = stat_ff;
		if (launch) begin
			if (pwdata == ddt_pkg::TRIG_PH1) begin
				nxt_stat = 32'h0000_0000;
			end else begin
				nxt_stat = stat_ff & ~(ddt_pkg::STAT_DONE | ddt_pkg::STAT_ERR);
			end
		end else if (finish) begin
			nxt_stat = stat_ff | ddt_pkg::STAT_DONE | result; // [R04] [R07]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tr_ff   <= ddt_pkg::TR_IDLE;
			tcnt_ff <= 8'h00;
			trig_ff <= 32'h0000_0000;
		end else begin
			case (tr_ff)
				ddt_pkg::TR_IDLE: begin
					if (launch) begin
						tr_ff   <= ddt_pkg::TR_RUN; // [R03]
						tcnt_ff <= 8'h00;
						trig_ff <= pwdata;
					end
				end
				ddt_pkg::TR_RUN: begin
					if (finish) begin
						tr_ff <= ddt_pkg::TR_IDLE; // [R04]
					end else begin
						tcnt_ff <= tcnt_ff + 8'h01;
					end
				end
				default: tr_ff <= ddt_pkg::TR_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_ff <= 32'h0000_0000;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// inversion control: shadow written by software, active copy moved only while traffic held
	assign apply = (ctrl_ff[ddt_pkg::C_DEQ] && widle && ridle) || training_busy; // [R17] [R19]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inv_sh_ff <= '0;
		end else if (wr_acc && paddr == ddt_pkg::A_INV
			&& !(pwdata[ddt_pkg::I_WR] && pwdata[ddt_pkg::I_DM])) begin
			inv_sh_ff.rd_dbi   <= pwdata[ddt_pkg::I_RD]; // [R15]
			inv_sh_ff.wr_dbi   <= pwdata[ddt_pkg::I_WR]; // [R12]
			inv_sh_ff.dm       <= pwdata[ddt_pkg::I_DM];
			inv_sh_ff.phy_mode <= pwdata[ddt_pkg::I_PHY];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inv_ff <= '0;
		end else if (apply) begin
			inv_ff <= inv_sh_ff; // [R19]
		end
	end

	// the phy sees no inversion request for x4 parts
	always_comb begin
		inv_cfg          = inv_ff;
		inv_cfg.rd_dbi   = inv_ff.rd_dbi && dbi_ok; // [R11]
		inv_cfg.wr_dbi   = inv_ff.wr_dbi && dbi_ok;
	end

	assign wdbi = inv_ff.wr_dbi && dbi_ok;
	assign wenc = wdbi && !inv_ff.phy_mode; // [R14]
	assign rdec = inv_ff.rd_dbi && dbi_ok && !inv_ff.phy_mode; // [R13] [R14]

	// sticky faults: set wins over a write-one clear
	assign mviol_clr = wr_acc && paddr == ddt_pkg::A_PIPE && pwdata[ddt_pkg::P_MVIOL];
	assign conf_clr  = wr_acc && paddr == ddt_pkg::A_PIPE && pwdata[ddt_pkg::P_CONF];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mviol_ff <= 1'b0;
			conf_ff  <= 1'b0;
		end else begin
			mviol_ff <= bad_wr || (mviol_ff && !mviol_clr); // [R12]
			conf_ff  <= (wr_acc && paddr == ddt_pkg::A_INV && pwdata[ddt_pkg::I_WR]
				&& pwdata[ddt_pkg::I_DM]) || (conf_ff && !conf_clr); // [R12]
		end
	end

	// command acceptance
	assign cmd_ready = !ctrl_ff[ddt_pkg::C_DEQ] && !training_busy && ctrl_ff[ddt_pkg::C_FRST]
		&& (cmd_write || rpend_ff != 4'hF); // [R18]
	assign acc_wr = cmd_valid && cmd_ready && cmd_write;
	assign acc_rd = cmd_valid && cmd_ready && !cmd_write;
	// a masked write with write inversion on is dropped, never sent
	assign bad_wr = acc_wr && wdbi && (|cmd_wr.mask); // [R12]

	ddt_dbi_enc u_enc (
		.data_i (cmd_wr.data),
		.en     (wenc),
		.data_o (enc_data),
		.flag_o (enc_flag)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dfi_wr_ff <= '0;
		end else begin
			dfi_wr_ff.wrdata_en <= acc_wr && !bad_wr;
			if (acc_wr) begin
				dfi_wr_ff.wrdata <= enc_data; // [R09] [R13]
				if (wenc) begin
					dfi_wr_ff.wrdata_mask <= enc_flag; // [R10] [R14]
				end else if (inv_ff.dm) begin
					dfi_wr_ff.wrdata_mask <= cmd_wr.mask;
				end else begin
					dfi_wr_ff.wrdata_mask <= 8'h00;
				end
			end
		end
	end

	assign dfi_wr = dfi_wr_ff;
	assign widle  = !dfi_wr_ff.wrdata_en; // [R18]

	// read path; a held fifo reset flushes whatever is in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rpend_ff <= 4'h0;
			rden_ff  <= 1'b0;
		end else begin
			rden_ff <= acc_rd;
			if (!ctrl_ff[ddt_pkg::C_FRST]) begin
				rpend_ff <= 4'h0; // [R02]
			end else if (acc_rd && !(dfi_rddata_valid && rpend_ff != 4'h0)) begin
				rpend_ff <= rpend_ff + 4'h1;
			end else if (!acc_rd && dfi_rddata_valid && rpend_ff != 4'h0) begin
				rpend_ff <= rpend_ff - 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ff <= '0;
		end else begin
			rd_ff.valid <= dfi_rddata_valid && ctrl_ff[ddt_pkg::C_FRST] && rpend_ff != 4'h0; // [R02]
			if (dfi_rddata_valid) begin
				rd_ff.data <= rdec ? (dfi_rddata ^ ddt_pkg::spread(dfi_rddata_dbi))
					: dfi_rddata; // [R10] [R13] [R14]
			end
		end
	end

	assign dfi_rddata_en = rden_ff;
	assign rd_ret        = rd_ff;
	assign ridle         = rpend_ff == 4'h0 && !rd_ff.valid && !rden_ff; // [R18]

	always_comb begin
		wr_zero_ok = 1'b1;
		for (int i = 0; i < ddt_pkg::NBYTES; i++) begin
			if (ddt_pkg::zeros(dfi_wr_ff.wrdata[8*i +: 8]) > 4'(ddt_pkg::ZERO_LIMIT)) begin
				wr_zero_ok = 1'b0;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_launch;
		launch;
	endsequence

	sequence s_run_done;
		(training_busy && !stat_ff[0]) ##T_RUN (!training_busy && stat_ff[0]);
	endsequence

	a_trig_launch: assert property (s_launch |=> s_run_done) // [R03]
		else $error("training phase did not run for its fixed length");
	a_done_flag: assert property (finish |=> stat_ff[0] && !training_busy) // [R04]
		else $error("done flag not set at end of training phase");
	a_pass_word: assert property (finish && trig_ff == ddt_pkg::TRIG_PH2 && ph1_ok
		&& phy_read_mode_sel == ddt_pkg::RDM_STATIC && stat_ff == ddt_pkg::STAT_PH1
		|=> stat_ff == ddt_pkg::STAT_PASS) // [R06] [R07]
		else $error("passing training did not report the pass word");
	a_phy_read_mode_sel_need: assert property (finish && trig_ff == ddt_pkg::TRIG_PH2
		&& phy_read_mode_sel != ddt_pkg::RDM_STATIC |=> stat_ff[20] && stat_ff[31:4] != 28'h8000_2FF) // [R05]
		else $error("second phase passed without static read mode");
	a_wr_invert: assert property (dfi_wr_ff.wrdata_en && $past(wenc) |-> wr_zero_ok) // [R09]
		else $error("written byte still carries more than four zeros");
	a_phy_plain: assert property ($past(acc_wr) && $past(!wenc) |-> dfi_wr_ff.wrdata == $past(cmd_wr.data)) // [R11] [R13]
		else $error("write data altered without controller inversion");
	a_rd_decode: assert property (dfi_rddata_valid && rdec |=> rd_ff.data ==
		($past(dfi_rddata) ^ ddt_pkg::spread($past(dfi_rddata_dbi)))) // [R14]
		else $error("read bytes not flipped per inversion flag");
	a_rd_ignore: assert property (dfi_rddata_valid && !rdec |=> rd_ff.data == $past(dfi_rddata)) // [R13]
		else $error("read data flipped while flags must be ignored");
	a_mask_excl: assert property ((!(inv_ff.wr_dbi && inv_ff.dm)) and (bad_wr |=> !dfi_wr_ff.wrdata_en)) // [R12]
		else $error("masked write issued with write inversion active");
	a_deq_stop: assert property (ctrl_ff[ddt_pkg::C_DEQ] |-> !cmd_ready ##1 !cmd_ready || !ctrl_ff[ddt_pkg::C_DEQ]) // [R18]
		else $error("command accepted while dequeue inhibited");
	a_cfg_static: assert property (!apply |=> $stable(inv_ff)) // [R19]
		else $error("inversion setting changed while traffic flowing");
	a_fifo_flush: assert property (!phy_fifo_reset_n |=> rpend_ff == 4'h0 && !rd_ff.valid) // [R02]
		else $error("read pipe not flushed under fifo reset");

endmodule // ddt_ctrl

// *** bench/ddt_phy_model.sv ***
`timescale 1ns/1ns
module ddt_phy_model (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 training_busy,
	input  wire logic                 phy_fifo_reset_n,
	input  wire ddt_pkg::ddt_inv_s    inv_cfg,
	input  wire ddt_pkg::ddt_dfi_wr_s dfi_wr,
	input  wire logic                 dfi_rddata_en,
	input  wire logic [3:0]           lat,
	output logic                      phy_init_complete,
	output logic                      dfi_rddata_valid,
	output logic      [63:0]          dfi_rddata,
	output logic      [7:0]           dfi_rddata_dbi
);
	logic [63:0] mem_ff;
	logic [63:0] snap;
	logic [63:0] dat_q[$];
	logic [63:0] b;
	logic [7:0]  f;
	int          due_q[$];
	int          now_ff;
	int          last_ff;
	int          t;

	// drops while a phase runs, so the controller has to mask it
	assign phy_init_complete = presetn && !training_busy;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ff = 64'h0;
			now_ff = 0;
			last_ff = 0;
			due_q.delete();
			dat_q.delete();
			dfi_rddata_valid <= 1'h0;
			dfi_rddata <= 64'h0;
			dfi_rddata_dbi <= 8'h0;
		end else begin
			now_ff = now_ff + 1;
			if (dfi_wr.wrdata_en) begin
				for (int i = 0; i < 8; i++) begin
					if (inv_cfg.wr_dbi && !inv_cfg.phy_mode) begin
						mem_ff[8*i +: 8] = dfi_wr.wrdata[8*i +: 8] ^ {8{dfi_wr.wrdata_mask[i]}};
					end else if (!dfi_wr.wrdata_mask[i]) begin
						mem_ff[8*i +: 8] = dfi_wr.wrdata[8*i +: 8];
					end
				end
			end
			if (!phy_fifo_reset_n) begin
				due_q.delete();
				dat_q.delete();
			end else if (dfi_rddata_en) begin
				// data is taken when the read issues, so later writes never leak into it
				dat_q.push_back(mem_ff);
				t = now_ff + int'(lat) + 1;
				if (t <= last_ff) begin
					t = last_ff + 1;
				end
				due_q.push_back(t);
				last_ff = t;
			end
			if (due_q.size() > 0 && due_q[0] == now_ff) begin
				void'(due_q.pop_front());
				snap = dat_q.pop_front();
				for (int i = 0; i < 8; i++) begin
					f[i] = inv_cfg.rd_dbi && !inv_cfg.phy_mode && $countones(~snap[8*i +: 8]) > 4;
					b[8*i +: 8] = snap[8*i +: 8] ^ {8{f[i]}};
				end
				dfi_rddata_valid <= 1'h1;
				dfi_rddata <= b;
				dfi_rddata_dbi <= f;
			end else begin
				// a released bus keeps moving so stale data never passes for a beat
				dfi_rddata_valid <= 1'h0;
				dfi_rddata <= ~dfi_rddata;
				dfi_rddata_dbi <= ~dfi_rddata_dbi;
			end
		end
	end
endmodule // ddt_phy_model

// *** bench/testbench.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_write, cmd_ready;
	logic                 refresh_inhibit, low_power_entry_enable, init_complete_enable, phy_init_complete;
	logic                 init_complete, phy_fifo_reset_n, training_busy, dfi_rddata_en, dfi_rddata_valid, ew, dmode;
	logic [7:0]           paddr, dfi_rddata_dbi;
	logic [31:0]          pwdata, prdata, r;
	logic [63:0]          dfi_rddata, mem;
	logic [1:0]           phy_read_mode_sel;
	logic [3:0]           lat, sh;
	ddt_pkg::ddt_inv_s    inv_cfg;
	ddt_pkg::ddt_wr_s     cmd_wr;
	ddt_pkg::ddt_dfi_wr_s dfi_wr;
	ddt_pkg::ddt_rd_s     rd_ret;
	logic [32:0]          apb_q[$];
	logic [71:0]          wr_q[$];
	logic [63:0]          rd_q[$];
	int                   err_count, samples_checked, cyc;

	ddt_ctrl u_ddt_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.refresh_inhibit, .low_power_entry_enable, .init_complete_enable, .phy_init_complete, .init_complete,
		.phy_fifo_reset_n, .phy_read_mode_sel, .training_busy, .inv_cfg, .cmd_valid, .cmd_write, .cmd_wr,
		.cmd_ready, .dfi_wr, .dfi_rddata_en, .dfi_rddata_valid, .dfi_rddata, .dfi_rddata_dbi, .rd_ret);
	ddt_phy_model u_ddt_phy_model (.pclk, .presetn, .training_busy, .phy_fifo_reset_n, .inv_cfg, .dfi_wr,
		.dfi_rddata_en, .lat, .phy_init_complete, .dfi_rddata_valid, .dfi_rddata, .dfi_rddata_dbi);

	initial pclk = 1'h0;
	always #50 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
		if (psel && penable && !pwrite && apb_q.size() > 0) `CHK({pslverr, prdata}, apb_q.pop_front())
		if (dfi_wr.wrdata_en === 1'h1) `CHK({dfi_wr.wrdata, dfi_wr.wrdata_mask}, wr_q.pop_front())
		if (rd_ret.valid === 1'h1) `CHK(rd_ret.data, rd_q.pop_front())
	end

	function automatic logic [71:0] enc(input logic [63:0] d);
		logic [7:0] f;
		for (int i = 0; i < 8; i++) begin
			f[i] = $countones(~d[8*i +: 8]) > 4;
			d[8*i +: 8] = d[8*i +: 8] ^ {8{f[i]}};
		end
		return {d, f};
	endfunction

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		r = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'h0);
		apb_q.push_back({err, e});
		apb(a, 1'h0, 32'h0);
	endtask

	task automatic cmd(input logic w, input logic [63:0] d, input logic [7:0] m);
		int n;
		n = 0;
		cmd_valid <= 1'h1;
		cmd_write <= w;
		cmd_wr <= {d, m};
		do begin
			@(posedge pclk);
			n++;
		end while (cmd_ready !== 1'h1 && n < 200);
		if (!w) begin
			rd_q.push_back(mem);
		end else if (!(ew && m != 8'h0)) begin
			wr_q.push_back(ew ? enc(d) : {d, dmode ? m : 8'h0});
			for (int i = 0; i < 8; i++) begin
				if (!(dmode && m[i])) begin
					mem[8*i +: 8] = d[8*i +: 8];
				end
			end
		end
	endtask

	task automatic burst(input int k);
		lat <= 4'($urandom_range(1, 6));
		for (int j = 0; j < k; j++) begin
			cmd(1'($urandom), {$urandom, $urandom}, dmode ? 8'($urandom) : 8'h0);
		end
		cmd_valid <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic train(input logic [31:0] w);
		int n;
		n = 0;
		apb(ddt_pkg::A_TRIG, 1'h1, w);
		apb(ddt_pkg::A_TRIG, 1'h1, 32'h0000_0003);
		`CHK(training_busy, 1'h1)
		`CHK(init_complete, 1'h0)
		do apb(ddt_pkg::A_STAT, 1'h0, 32'h0); while (r[0] !== 1'h1 && n++ < 40);
		if (r[0] !== 1'h1) begin
			err_count++;
		end
		rd(ddt_pkg::A_TRIG, w);
	endtask

	task automatic setcfg(input logic [1:0] dw, input logic [3:0] m);
		int          n;
		logic [31:0] c;
		n = 0;
		c = {22'h0, dw, 8'h34};
		apb(ddt_pkg::A_CTRL, 1'h1, c | 32'h0000_0008);
		`CHK(cmd_ready, 1'h0)
		do apb(ddt_pkg::A_PIPE, 1'h0, 32'h0); while (r[1:0] !== 2'h3 && n++ < 40);
		if (r[1:0] !== 2'h3) begin
			err_count++;
		end
		apb(ddt_pkg::A_INV, 1'h1, {28'h0, m});
		if (m[1] && m[2]) begin
			rd(ddt_pkg::A_INV, {28'h0, sh});
			rd(ddt_pkg::A_PIPE, 32'h0000_000B);
			apb(ddt_pkg::A_PIPE, 1'h1, 32'h0000_0008);
		end else begin
			sh = m;
		end
		apb(ddt_pkg::A_CTRL, 1'h1, c);
		ew = sh[1] && !sh[3] && dw != 2'h0;
		dmode = sh[2];
		`CHK(inv_cfg, {sh[0] && dw != 2'h0, ew || (sh[1] && dw != 2'h0), sh[2], sh[3]})
		if (ew) begin
			cmd(1'h1, {$urandom, $urandom}, 8'h01);
			cmd_valid <= 1'h0;
			@(posedge pclk);
			rd(ddt_pkg::A_PIPE, 32'h0000_0007);
			apb(ddt_pkg::A_PIPE, 1'h1, 32'h0000_0004);
		end
	endtask

	initial begin
		{presetn, psel, penable, pwrite, cmd_valid, cmd_write, ew, dmode} = 8'h0;
		{paddr, pwdata, cmd_wr, mem, lat, sh} = '0;
		r = $urandom(32'h480C);
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(ddt_pkg::A_CTRL, ddt_pkg::CTRL_RST);
		rd(ddt_pkg::A_STAT, 32'h0);
		rd(ddt_pkg::A_PIPE, 32'h0000_0003);
		rd(8'h14, 32'h0, 1'h1);
		apb(ddt_pkg::A_CTRL, 1'h1, 32'h0000_0101);
		`CHK({refresh_inhibit, low_power_entry_enable, phy_fifo_reset_n, cmd_ready}, 4'h8)
		apb(ddt_pkg::A_CTRL, 1'h1, 32'h0000_0111);
		`CHK(phy_fifo_reset_n, 1'h1)
		train(ddt_pkg::TRIG_PH1);
		rd(ddt_pkg::A_STAT, 32'h0000_000F);
		// second phase without static read mode has to be refused
		train(ddt_pkg::TRIG_PH2);
		rd(ddt_pkg::A_STAT, 32'h0010_000F);
		apb(ddt_pkg::A_CTRL, 1'h1, 32'h0000_0131);
		`CHK(phy_read_mode_sel, 2'h1)
		train(ddt_pkg::TRIG_PH2);
		rd(ddt_pkg::A_STAT, 32'h8000_2FFF);
		apb(ddt_pkg::A_CTRL, 1'h1, 32'h0000_0121);
		`CHK(phy_fifo_reset_n, 1'h0)
		apb(ddt_pkg::A_CTRL, 1'h1, 32'h0000_0134);
		`CHK({refresh_inhibit, low_power_entry_enable, init_complete}, 3'h1)
		// an enable written outside the hold window stays in the shadow
		apb(ddt_pkg::A_INV, 1'h1, 32'h0000_0001);
		`CHK(inv_cfg, 4'h0)
		sh = 4'h1;
		burst(8);
		for (int k = 0; k < 3; k++) begin
			for (int m = 0; m < 16; m++) begin
				setcfg(2'((k + 1) % 3), 4'(m));
				burst(6);
			end
		end
		repeat (40) @(posedge pclk);
		`CHK(wr_q.size() + rd_q.size(), 0)
		tally_and_finish();
	end
endmodule // testbench
